// ===== dv/config_pin_function_mux_tb.sv
`timescale 1ns/1ps
`default_nettype none
module config_pin_function_mux_tb;
  typedef struct packed {
    logic [4:0] fn;
    cpfm_pkg::cpfm_usb_t u;
    cpfm_pkg::cpfm_act_t a;
    cpfm_pkg::cpfm_clk_t c;
    cpfm_pkg::cpfm_bb_t b;
    logic oe_n;
    logic out;
  } cpfm_row_t;

  localparam cpfm_row_t ROWS [24] = '{
    '{cpfm_pkg::FN_TRISTATE, 4'h0, 3'h0, 3'h0, 2'h3, 1'b1, 1'b0},
    '{cpfm_pkg::FN_DRIVE1, 4'h0, 3'h0, 3'h0, 2'h3, 1'b0, 1'b1},
    '{cpfm_pkg::FN_DRIVE0, 4'h0, 3'h0, 3'h0, 2'h3, 1'b0, 1'b0},
    '{cpfm_pkg::FN_LINE_DRIVER_TX_ENABLE, 4'h0, 3'h4, 3'h0, 2'h3, 1'b0, 1'b1},
    '{cpfm_pkg::FN_LINE_DRIVER_TX_ENABLE, 4'h0, 3'h3, 3'h0, 2'h3, 1'b0, 1'b0},
    '{cpfm_pkg::FN_POWER_ENABLE_N, 4'h8, 3'h0, 3'h0, 2'h3, 1'b0, 1'b0},
    '{cpfm_pkg::FN_POWER_ENABLE_N, 4'hC, 3'h0, 3'h0, 2'h3, 1'b0, 1'b1},
    '{cpfm_pkg::FN_UP_LED, 4'h8, 3'h2, 3'h0, 2'h3, 1'b0, 1'b0},
    '{cpfm_pkg::FN_UP_LED, 4'h8, 3'h1, 3'h0, 2'h3, 1'b0, 1'b1},
    '{cpfm_pkg::FN_DN_LED, 4'h8, 3'h1, 3'h0, 2'h3, 1'b0, 1'b0},
    '{cpfm_pkg::FN_DN_LED, 4'h8, 3'h2, 3'h0, 2'h3, 1'b0, 1'b1},
    '{cpfm_pkg::FN_ANY_LED, 4'h8, 3'h2, 3'h0, 2'h3, 1'b0, 1'b0},
    '{cpfm_pkg::FN_ANY_LED, 4'h8, 3'h0, 3'h0, 2'h3, 1'b0, 1'b1},
    '{cpfm_pkg::FN_SLEEP, 4'hC, 3'h0, 3'h0, 2'h3, 1'b0, 1'b0},
    '{cpfm_pkg::FN_SLEEP, 4'h8, 3'h0, 3'h0, 2'h3, 1'b0, 1'b1},
    '{cpfm_pkg::FN_CLK_FAST, 4'h8, 3'h0, 3'h4, 2'h3, 1'b0, 1'b1},
    '{cpfm_pkg::FN_CLK_MID, 4'h8, 3'h0, 3'h5, 2'h3, 1'b0, 1'b0},
    '{cpfm_pkg::FN_CLK_SLOW, 4'h8, 3'h0, 3'h1, 2'h3, 1'b0, 1'b1},
    '{cpfm_pkg::FN_CLK_FAST, 4'hC, 3'h0, 3'h7, 2'h3, 1'b0, 1'b0},
    '{cpfm_pkg::FN_CHARGER, 4'h1, 3'h0, 3'h0, 2'h3, 1'b0, 1'b1},
    '{cpfm_pkg::FN_CHARGER_N, 4'h1, 3'h0, 3'h0, 2'h3, 1'b0, 1'b0},
    '{cpfm_pkg::FN_BB_WR, 4'h0, 3'h0, 3'h0, 2'h1, 1'b0, 1'b0},
    '{cpfm_pkg::FN_BB_RD, 4'h0, 3'h0, 3'h0, 2'h2, 1'b0, 1'b0},
    '{5'h1F, 4'h0, 3'h0, 3'h0, 2'h3, 1'b1, 1'b0}
  };

  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0] s_wstrb = 4'hF;
  logic [1:0] s_bresp, s_rresp;
  logic s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  cpfm_pkg::cpfm_usb_t usb;
  cpfm_pkg::cpfm_act_t act;
  cpfm_pkg::cpfm_clk_t clks;
  cpfm_pkg::cpfm_bb_t bb;
  logic config_pin_in, config_pin_out, config_pin_oe_n, pull_up_en, pull_down_en;
  logic core_txd, core_rts_n, txd, rts_n, rxd, cts_n, core_rxd, core_cts_n;
  logic vbus_present, suspend_inhibit, gpio_in, ext_en, ext_level;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;

  always #4 core_clk = ~core_clk;

  cpfm_top dut (.core_clk, .rstn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .usb, .act, .clks, .bb, .config_pin_in,
    .config_pin_out, .config_pin_oe_n, .pull_up_en, .pull_down_en, .core_txd, .core_rts_n,
    .txd, .rts_n, .rxd, .cts_n, .core_rxd, .core_cts_n, .vbus_present, .suspend_inhibit,
    .gpio_in);

  cpfm_board board (.core_clk, .pin_out(config_pin_out), .pin_oe_n(config_pin_oe_n),
    .pull_up_en, .pull_down_en, .ext_en, .ext_level, .pin_level(config_pin_in));

  task automatic finish_test;
    $display("Mismatches %0d of %0d compares", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      finish_test;
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      err_total++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh, bh;
    @(posedge core_clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    bh = 1'b0;
    while (!bh)
    begin
      @(negedge core_clk);
      ah = s_awvalid & s_awready;
      wh = s_wvalid & s_wready;
      bh = s_bvalid;
      r = s_bresp;
      @(posedge core_clk);
      if (ah)
        s_awvalid <= 1'b0;
      if (wh)
        s_wvalid <= 1'b0;
      if (bh)
        s_bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    @(posedge core_clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    rh = 1'b0;
    while (!rh)
    begin
      @(negedge core_clk);
      ah = s_arvalid & s_arready;
      rh = s_rvalid;
      d = s_rdata;
      r = s_rresp;
      @(posedge core_clk);
      if (ah)
        s_arvalid <= 1'b0;
      if (rh)
        s_rready <= 1'b0;
    end
  endtask

  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    logic p;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
    {s_awaddr, s_araddr, s_wdata} = 48'h0;
    {usb, act, clks, bb} = 12'h003;
    {core_txd, core_rts_n, rxd, cts_n, ext_en, ext_level} = 6'h3C;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    chk(32'(pull_up_en), 32'h1);
    chk(32'(config_pin_oe_n), 32'h1);
    rd(cpfm_pkg::ADDR_SELECT, d, r);
    chk(d, 32'(cpfm_pkg::FN_LINE_DRIVER_TX_ENABLE));
    foreach (ROWS[i])
    begin
      wr(cpfm_pkg::ADDR_SELECT, 32'(ROWS[i].fn), r);
      usb <= ROWS[i].u;
      act <= ROWS[i].a;
      clks <= ROWS[i].c;
      bb <= ROWS[i].b;
      step(3);
      chk(32'(config_pin_oe_n), 32'(ROWS[i].oe_n));
      if (ROWS[i].oe_n == 1'b0)
        chk(32'(config_pin_out), 32'(ROWS[i].out));
    end
    rd(8'h0C, d, r);
    chk({d[29:0], r}, 32'(cpfm_pkg::RESP_SLVERR));
    wr(8'h10, 32'h0, r);
    chk(32'(r), 32'(cpfm_pkg::RESP_SLVERR));
    wr(cpfm_pkg::ADDR_OPTIONS, 32'h6, r);
    wr(cpfm_pkg::ADDR_SELECT, 32'(cpfm_pkg::FN_GPIO), r);
    step(3);
    chk({30'h0, config_pin_oe_n, config_pin_out}, 32'h1);
    wr(cpfm_pkg::ADDR_OPTIONS, 32'h0, r);
    ext_en <= 1'b1;
    ext_level <= 1'b1;
    step(3);
    chk({30'h0, config_pin_oe_n, gpio_in}, 32'h3);
    rd(cpfm_pkg::ADDR_STATUS, d, r);
    chk(d, 32'h1);
    wr(cpfm_pkg::ADDR_SELECT, 32'(cpfm_pkg::FN_KEEP), r);
    ext_level <= 1'b0;
    step(3);
    chk(32'(suspend_inhibit), 32'h1);
    wr(cpfm_pkg::ADDR_SELECT, 32'(cpfm_pkg::FN_VBUS), r);
    ext_level <= 1'b1;
    step(3);
    chk({30'h0, vbus_present, suspend_inhibit}, 32'h2);
    wr(cpfm_pkg::ADDR_OPTIONS, 32'h1, r);
    ext_en <= 1'b0;
    usb <= 4'hC;
    step(3);
    chk({30'h0, pull_up_en, pull_down_en}, 32'h1);
    wr(cpfm_pkg::ADDR_SELECT, 32'(cpfm_pkg::FN_TOGGLE), r);
    usb <= 4'h8;
    core_txd <= 1'b0;
    rxd <= 1'b0;
    step(3);
    chk({28'h0, txd, rts_n, core_rxd, core_cts_n}, 32'h5);
    chk(32'(pull_up_en), 32'h1);
    p = config_pin_out;
    repeat (2)
    begin
      @(posedge core_clk);
      usb <= 4'hA;
      @(posedge core_clk);
      usb <= 4'h8;
      step(2);
      p = ~p;
      chk(32'(config_pin_out), 32'(p));
    end
    @(posedge core_clk);
    s_wstrb <= 4'hE;
    wr(cpfm_pkg::ADDR_SELECT, 32'(cpfm_pkg::FN_DRIVE1), r);
    s_wstrb <= 4'hF;
    chk(32'(r), 32'(cpfm_pkg::RESP_OKAY));
    rd(cpfm_pkg::ADDR_SELECT, d, r);
    chk(d, 32'(cpfm_pkg::FN_TOGGLE));
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    chk({30'h0, config_pin_oe_n, config_pin_out}, 32'h2);
    rd(cpfm_pkg::ADDR_SELECT, d, r);
    chk(d, 32'(cpfm_pkg::FN_LINE_DRIVER_TX_ENABLE));
    rd(cpfm_pkg::ADDR_OPTIONS, d, r);
    chk(d, 32'h0);
    finish_test;
  end
endmodule // config_pin_function_mux_tb
`default_nettype wire

// ===== dv/cpfm_board.sv
`timescale 1ns/1ps
`default_nettype none
module cpfm_board (
  input wire logic core_clk,
  input wire logic pin_out,
  input wire logic pin_oe_n,
  input wire logic pull_up_en,
  input wire logic pull_down_en,
  input wire logic ext_en,
  input wire logic ext_level,
  output logic pin_level
);
  logic flip = 1'b0;

  // Unpulled, undriven pad wanders
  always_ff @(posedge core_clk)
  begin
    flip <= ~flip;
  end

  always_comb
  begin
    if (!pin_oe_n)
      pin_level = pin_out;
    else if (ext_en)
      pin_level = ext_level;
    else if (pull_up_en)
      pin_level = 1'b1;
    else if (pull_down_en)
      pin_level = 1'b0;
    else
      pin_level = flip;
  end
endmodule // cpfm_board
`default_nettype wire

// ===== logic/cpfm_pkg.sv
`default_nettype none
package cpfm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FN_W = 5;
  localparam int OPT_W = 3;
  localparam int STAT_W = 5;

  // Pin function codes
  localparam logic [4:0] FN_TRISTATE = 5'h00;
  localparam logic [4:0] FN_DRIVE1 = 5'h01;
  localparam logic [4:0] FN_DRIVE0 = 5'h02;
  localparam logic [4:0] FN_LINE_DRIVER_TX_ENABLE = 5'h03;
  localparam logic [4:0] FN_POWER_ENABLE_N = 5'h04;
  localparam logic [4:0] FN_UP_LED = 5'h05;
  localparam logic [4:0] FN_DN_LED = 5'h06;
  localparam logic [4:0] FN_ANY_LED = 5'h07;
  localparam logic [4:0] FN_SLEEP = 5'h08;
  localparam logic [4:0] FN_CLK_FAST = 5'h09;
  localparam logic [4:0] FN_CLK_MID = 5'h0A;
  localparam logic [4:0] FN_CLK_SLOW = 5'h0B;
  localparam logic [4:0] FN_GPIO = 5'h0C;
  localparam logic [4:0] FN_CHARGER = 5'h0D;
  localparam logic [4:0] FN_CHARGER_N = 5'h0E;
  localparam logic [4:0] FN_BB_WR = 5'h0F;
  localparam logic [4:0] FN_BB_RD = 5'h10;
  localparam logic [4:0] FN_VBUS = 5'h11;
  localparam logic [4:0] FN_TOGGLE = 5'h12;
  localparam logic [4:0] FN_KEEP = 5'h13;

  // Register byte offsets
  localparam logic [7:0] ADDR_SELECT = 8'h00;
  localparam logic [7:0] ADDR_OPTIONS = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic gpio_drive;
    logic gpio_value;
    logic suspend_pull_down;
  } cpfm_opt_t;

  typedef struct packed {
    logic suspended;
    logic pin_out;
    logic keep_awake;
    logic vbus_present;
    logic pin_in;
  } cpfm_status_t;

  typedef struct packed {
    logic configured;
    logic suspended;
    logic sof;
    logic charger_port;
  } cpfm_usb_t;

  typedef struct packed {
    logic tx_busy;
    logic upstream;
    logic downstream;
  } cpfm_act_t;

  typedef struct packed {
    logic fast;
    logic mid;
    logic slow;
  } cpfm_clk_t;

  typedef struct packed {
    logic wr_n;
    logic rd_n;
  } cpfm_bb_t;

  localparam logic [4:0] SELECT_RST = FN_LINE_DRIVER_TX_ENABLE;
  localparam cpfm_opt_t OPTIONS_RST = 3'h0;

  typedef enum logic [1:0] {
    WS_IDLE = 2'b01,
    WS_RESP = 2'b10
  } cpfm_wstate_t;

  typedef enum logic [1:0] {
    RS_IDLE = 2'b01,
    RS_DATA = 2'b10
  } cpfm_rstate_t;
endpackage
`default_nettype wire

// ===== logic/cpfm_top.sv
// Notes on behaviour
// - Stored selection picks pin function; default transmit-enable
// - Tri-state, constant one or constant zero
// - Transmit-enable high while serial data sends
// - Power enable low configured, high suspended
// - Upstream LED low while forwarding to host
// - Downstream LED low while sending host data
// - Combined LED low on either direction
// - Sleep output low during suspend
// - Output fast, mid or slow clock
// - Clocks stop while suspended
// - Host reads and drives pin as GPIO
// - Charger detect high, inverted option complements
// - Bit-bang write strobe routed to pin
// - Bit-bang read strobe routed to pin
// - Bus-power sense pin sampled as input
// - Pin toggles on each start-of-frame
// - Active-low keep-awake input blocks suspend
// - Input pins weakly pulled up
// - Optional weak pull-down during suspend
// - Serial outputs driven, serial inputs received
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cpfm_top (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire cpfm_pkg::cpfm_usb_t usb,
  input wire cpfm_pkg::cpfm_act_t act,
  input wire cpfm_pkg::cpfm_clk_t clks,
  input wire cpfm_pkg::cpfm_bb_t bb,
  input wire logic config_pin_in,
  output logic config_pin_out,
  output logic config_pin_oe_n,
  output logic pull_up_en,
  output logic pull_down_en,
  input wire logic core_txd,
  input wire logic core_rts_n,
  output logic txd,
  output logic rts_n,
  input wire logic rxd,
  input wire logic cts_n,
  output logic core_rxd,
  output logic core_cts_n,
  output logic vbus_present,
  output logic suspend_inhibit,
  output logic gpio_in
);
  function automatic logic fn_is_input(input logic [4:0] f);
    fn_is_input = (f == cpfm_pkg::FN_TRISTATE) || (f == cpfm_pkg::FN_VBUS) ||
                  (f == cpfm_pkg::FN_KEEP);
  endfunction
  function automatic logic fn_is_clock(input logic [4:0] f);
    fn_is_clock = (f == cpfm_pkg::FN_CLK_FAST) || (f == cpfm_pkg::FN_CLK_MID) ||
                  (f == cpfm_pkg::FN_CLK_SLOW);
  endfunction

  // Register file and bus state
  logic [4:0] sel;
  logic [4:0] next_sel;
  cpfm_pkg::cpfm_opt_t opt;
  cpfm_pkg::cpfm_opt_t next_opt;
  cpfm_pkg::cpfm_wstate_t wstate;
  cpfm_pkg::cpfm_wstate_t next_wstate;
  cpfm_pkg::cpfm_rstate_t rstate;
  cpfm_pkg::cpfm_rstate_t next_rstate;
  logic aw_got;
  logic next_aw_got;
  logic w_got;
  logic next_w_got;
  logic [7:0] awaddr_q;
  logic [7:0] next_awaddr;
  logic [31:0] wdata_q;
  logic [31:0] next_wdata;
  logic wstrb_q;
  logic next_wstrb;
  logic next_awready;
  logic next_wready;
  logic [1:0] next_bresp;
  logic next_bvalid;
  logic next_arready;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic next_rvalid;
  cpfm_pkg::cpfm_status_t stat;
  // Pin state
  logic toggle;
  logic next_toggle;
  logic suspended_q;
  logic next_suspended;
  logic next_pin_out;
  logic next_pin_oe_n;
  logic next_pull_up;
  logic next_pull_down;
  logic next_vbus;
  logic next_inhibit;
  logic checks_on;
  assign stat = {suspended_q, config_pin_out, suspend_inhibit, vbus_present, gpio_in};
  // Bus slave and registers
  always_comb
  begin
    next_sel = sel;
    next_opt = opt;
    next_wstate = wstate;
    next_rstate = rstate;
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_awaddr = awaddr_q;
    next_wdata = wdata_q;
    next_wstrb = wstrb_q;
    next_awready = s_awready;
    next_wready = s_wready;
    next_bresp = s_bresp;
    next_bvalid = s_bvalid;
    next_arready = s_arready;
    next_rdata = s_rdata;
    next_rresp = s_rresp;
    next_rvalid = s_rvalid;
    if (s_awvalid && s_awready)
    begin
      next_awaddr = s_awaddr;
      next_aw_got = 1'b1;
      next_awready = 1'b0;
    end
    if (s_wvalid && s_wready)
    begin
      next_wdata = s_wdata;
      next_wstrb = s_wstrb[0];
      next_w_got = 1'b1;
      next_wready = 1'b0;
    end
    case (wstate)
      cpfm_pkg::WS_IDLE:
      begin
        if (aw_got && w_got)
        begin
          next_aw_got = 1'b0;
          next_w_got = 1'b0;
          next_bvalid = 1'b1;
          next_bresp = cpfm_pkg::RESP_OKAY;
          next_wstate = cpfm_pkg::WS_RESP;
          if (awaddr_q == cpfm_pkg::ADDR_SELECT)
          begin
            if (wstrb_q)
              next_sel = wdata_q[cpfm_pkg::FN_W-1:0];
          end
          else if (awaddr_q == cpfm_pkg::ADDR_OPTIONS)
          begin
            if (wstrb_q)
              next_opt = wdata_q[cpfm_pkg::OPT_W-1:0];
          end
          else if (awaddr_q != cpfm_pkg::ADDR_STATUS)
            next_bresp = cpfm_pkg::RESP_SLVERR;
        end
      end
      cpfm_pkg::WS_RESP:
      begin
        if (s_bready)
        begin
          next_bvalid = 1'b0;
          next_awready = 1'b1;
          next_wready = 1'b1;
          next_wstate = cpfm_pkg::WS_IDLE;
        end
      end
      default:
        next_wstate = cpfm_pkg::WS_IDLE;
    endcase
    case (rstate)
      cpfm_pkg::RS_IDLE:
      begin
        if (s_arvalid && s_arready)
        begin
          next_arready = 1'b0;
          next_rvalid = 1'b1;
          next_rresp = cpfm_pkg::RESP_OKAY;
          next_rdata = 32'h00000000;
          next_rstate = cpfm_pkg::RS_DATA;
          if (s_araddr == cpfm_pkg::ADDR_SELECT)
            next_rdata = {27'h0000000, sel};
          else if (s_araddr == cpfm_pkg::ADDR_OPTIONS)
            next_rdata = {29'h00000000, opt};
          else if (s_araddr == cpfm_pkg::ADDR_STATUS)
            next_rdata = {27'h0000000, stat};
          else
            next_rresp = cpfm_pkg::RESP_SLVERR;
        end
      end
      cpfm_pkg::RS_DATA:
      begin
        if (s_rready)
        begin
          next_rvalid = 1'b0;
          next_arready = 1'b1;
          next_rstate = cpfm_pkg::RS_IDLE;
        end
      end
      default:
        next_rstate = cpfm_pkg::RS_IDLE;
    endcase
  end
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      sel <= cpfm_pkg::SELECT_RST;
      opt <= cpfm_pkg::OPTIONS_RST;
      wstate <= cpfm_pkg::WS_IDLE;
      rstate <= cpfm_pkg::RS_IDLE;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 1'b0;
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bresp <= 2'h0;
      s_bvalid <= 1'b0;
      s_arready <= 1'b1;
      s_rdata <= 32'h00000000;
      s_rresp <= 2'h0;
      s_rvalid <= 1'b0;
    end
    else
    begin
      sel <= next_sel;
      opt <= next_opt;
      wstate <= next_wstate;
      rstate <= next_rstate;
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      awaddr_q <= next_awaddr;
      wdata_q <= next_wdata;
      wstrb_q <= next_wstrb;
      s_awready <= next_awready;
      s_wready <= next_wready;
      s_bresp <= next_bresp;
      s_bvalid <= next_bvalid;
      s_arready <= next_arready;
      s_rdata <= next_rdata;
      s_rresp <= next_rresp;
      s_rvalid <= next_rvalid;
    end
  end

  // Pin function mux
  always_comb
  begin
    next_toggle = toggle;
    if ((sel == cpfm_pkg::FN_TOGGLE) && usb.sof)
      next_toggle = !toggle;
    next_pin_out = 1'b0;
    next_pin_oe_n = fn_is_input(sel);
    case (sel)
      cpfm_pkg::FN_TRISTATE: next_pin_out = 1'b0;
      cpfm_pkg::FN_DRIVE1: next_pin_out = 1'b1;
      cpfm_pkg::FN_DRIVE0: next_pin_out = 1'b0;
      cpfm_pkg::FN_LINE_DRIVER_TX_ENABLE: next_pin_out = act.tx_busy;
      cpfm_pkg::FN_POWER_ENABLE_N: next_pin_out = !(usb.configured && !usb.suspended);
      cpfm_pkg::FN_UP_LED: next_pin_out = !act.upstream;
      cpfm_pkg::FN_DN_LED: next_pin_out = !act.downstream;
      cpfm_pkg::FN_ANY_LED: next_pin_out = !(act.upstream || act.downstream);
      cpfm_pkg::FN_SLEEP: next_pin_out = !usb.suspended;
      cpfm_pkg::FN_CLK_FAST: next_pin_out = clks.fast;
      cpfm_pkg::FN_CLK_MID: next_pin_out = clks.mid;
      cpfm_pkg::FN_CLK_SLOW: next_pin_out = clks.slow;
      cpfm_pkg::FN_GPIO:
      begin
        next_pin_out = opt.gpio_value;
        next_pin_oe_n = !opt.gpio_drive;
      end
      cpfm_pkg::FN_CHARGER: next_pin_out = usb.charger_port;
      cpfm_pkg::FN_CHARGER_N: next_pin_out = !usb.charger_port;
      cpfm_pkg::FN_BB_WR: next_pin_out = bb.wr_n;
      cpfm_pkg::FN_BB_RD: next_pin_out = bb.rd_n;
      cpfm_pkg::FN_VBUS, cpfm_pkg::FN_KEEP: next_pin_out = 1'b0;
      cpfm_pkg::FN_TOGGLE: next_pin_out = next_toggle;
      default:
      begin
        next_pin_out = 1'b0;
        next_pin_oe_n = 1'b1;
      end
    endcase
    if (fn_is_clock(sel) && usb.suspended)
      next_pin_out = 1'b0;
    next_pull_down = opt.suspend_pull_down && usb.suspended;
    next_pull_up = !next_pull_down;
    next_vbus = (sel == cpfm_pkg::FN_VBUS) && config_pin_in;
    next_inhibit = (sel == cpfm_pkg::FN_KEEP) && !config_pin_in;
    next_suspended = usb.suspended;
  end
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      toggle <= 1'b0;
      suspended_q <= 1'b0;
      config_pin_out <= 1'b0;
      config_pin_oe_n <= 1'b1;
      pull_up_en <= 1'b1;
      pull_down_en <= 1'b0;
      txd <= 1'b1;
      rts_n <= 1'b1;
      core_rxd <= 1'b1;
      core_cts_n <= 1'b1;
      vbus_present <= 1'b0;
      suspend_inhibit <= 1'b0;
      gpio_in <= 1'b0;
      checks_on <= 1'b0;
    end
    else
    begin
      toggle <= next_toggle;
      suspended_q <= next_suspended;
      config_pin_out <= next_pin_out;
      config_pin_oe_n <= next_pin_oe_n;
      pull_up_en <= next_pull_up;
      pull_down_en <= next_pull_down;
      txd <= core_txd;
      rts_n <= core_rts_n;
      core_rxd <= rxd;
      core_cts_n <= cts_n;
      vbus_present <= next_vbus;
      suspend_inhibit <= next_inhibit;
      gpio_in <= config_pin_in;
      checks_on <= 1'b1;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn || !checks_on);
  a_default_select: assert property ($rose(rstn) |-> sel == cpfm_pkg::SELECT_RST)
    else $error("Selection not at default after reset");
  a_tristate_pin: assert property (fn_is_input(sel) |=> config_pin_oe_n)
    else $error("Input function drives pin");
  a_drive_one: assert property ((sel == cpfm_pkg::FN_DRIVE1) |=>
    (!config_pin_oe_n && config_pin_out))
    else $error("Constant one not driven");
  a_line_driver_tx_enable_follow: assert property ((sel == cpfm_pkg::FN_LINE_DRIVER_TX_ENABLE) |=>
    (config_pin_out == $past(act.tx_busy) && !config_pin_oe_n))
    else $error("Transmit enable wrong");
  a_power_enable: assert property ((sel == cpfm_pkg::FN_POWER_ENABLE_N) |=>
    config_pin_out == !($past(usb.configured) && !$past(usb.suspended)))
    else $error("Power enable wrong");
  a_any_led: assert property ((sel == cpfm_pkg::FN_ANY_LED && act.upstream) |=>
    !config_pin_out)
    else $error("Activity LED not low");
  a_sleep_level: assert property ((sel == cpfm_pkg::FN_SLEEP) |=>
    config_pin_out == !$past(usb.suspended))
    else $error("Sleep level wrong");
  a_clock_stop: assert property ((fn_is_clock(sel) && usb.suspended) |=>
    !config_pin_out)
    else $error("Clock runs in suspend");
  a_frame_toggle: assert property ((sel == cpfm_pkg::FN_TOGGLE &&
    $past(sel) == cpfm_pkg::FN_TOGGLE) |=>
    config_pin_out == ($past(config_pin_out) ^ $past(usb.sof)))
    else $error("Frame toggle wrong");
  a_keep_awake: assert property ((sel == cpfm_pkg::FN_KEEP) |=>
    suspend_inhibit == !$past(config_pin_in))
    else $error("Keep-awake wrong");
  a_vbus_sense: assert property ((sel != cpfm_pkg::FN_VBUS) |=> !vbus_present)
    else $error("Bus sense outside its function");
  a_pull_control: assert property (##1 pull_down_en ==
    ($past(opt.suspend_pull_down) && $past(usb.suspended)) && pull_up_en != pull_down_en)
    else $error("Pull control wrong");
  a_serial_pass: assert property (##1 txd == $past(core_txd) &&
    core_cts_n == $past(cts_n))
    else $error("Serial pin path wrong");
  a_read_answer: assert property ((s_arvalid && s_arready) |=> s_rvalid [*1] ##0 !s_arready)
    else $error("Read not answered");
  c_line_driver_tx_enable_active: cover property (sel == cpfm_pkg::FN_LINE_DRIVER_TX_ENABLE ##1 config_pin_out);
  c_frame_toggle: cover property (sel == cpfm_pkg::FN_TOGGLE && usb.sof ##2 config_pin_out);
  c_write_done: cover property (s_bvalid && s_bready);
  c_keep_awake: cover property (suspend_inhibit);
endmodule // cpfm_top
`default_nettype wire
